// ===== src/rtcsl_defines.svh
`ifndef RTCSL_DEFINES_SVH
`define RTCSL_DEFINES_SVH

// Bus address with the direction bit included, and its seven-bit form.
`define RTCSL_DEV_ADDR       7'h68
`define RTCSL_DEV_ADDR_BYTE  8'hd0
// Register pointer layout.
`define RTCSL_PTR_W          3
`define RTCSL_NUM_REGS       8
`define RTCSL_PTR_RESET      3'h0
`define RTCSL_PTR_LAST_TIME  3'h6
`define RTCSL_PTR_CALIB      3'h7
`define RTCSL_DATA_RESET     8'h00
// Recovery time after power returns.
`define RTCSL_CLK_HZ         20000000
`define RTCSL_REC_TIME_US    1000
`define RTCSL_REC_CYCLES     ((`RTCSL_REC_TIME_US * (`RTCSL_CLK_HZ / 1000000)))

`endif

// ===== src/rtcsl_pkg.sv
package rtcsl_pkg;

    typedef enum logic [2:0] {
        RTCSL_IDLE  = 3'b000,
        RTCSL_ADDR  = 3'b001,
        RTCSL_ACK   = 3'b010,
        RTCSL_RX    = 3'b011,
        RTCSL_TX    = 3'b100,
        RTCSL_TXACK = 3'b101,
        RTCSL_IGN   = 3'b110
    } rtcsl_state_e;

endpackage : rtcsl_pkg

// ===== src/rtcsl_regmem.sv
`timescale 1ns/1ps
`include "rtcsl_defines.svh"

module rtcsl_regmem (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Write port.
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Registered read port.
    input  wire logic [2:0] rd_addr,
    output logic      [7:0] rd_data
);

    logic [7:0] mem_q [0:`RTCSL_NUM_REGS-1];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `RTCSL_NUM_REGS; i++) begin
                mem_q[i] <= `RTCSL_DATA_RESET;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= `RTCSL_DATA_RESET;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule : rtcsl_regmem

// ===== src/rtcsl_slave.sv
`timescale 1ns/1ps
`include "rtcsl_defines.svh"

// How it works
// - Answer only bus address bytes D0h and D1h
// - Eight registers, seconds through calibration
// - Power fail aborts, clears pointer, ignores bus
// - Keep ignoring bus for recovery time
// - SDA falls with SCL high: start
// - SDA rises with SCL high: stop
// - SDA changes only while SCL low
// - Eight bits then receiver acknowledge bit
// - Unlimited bytes between start and stop
// - Master nack: device releases SDA
// - Acknowledge address, word address, data
// - First written byte loads pointer
// - Store data, pointer steps on ack
// - Random read via repeated start
// - Read pointer steps on ack clock
// - Freeze time copy while pointer 00h-06h
// - Bare read starts at held pointer
// - Time write completion resets divider chain
// - Time BCD, calibration plain binary
module rtcsl_slave #(
    parameter int unsigned REC_CYCLES = `RTCSL_REC_CYCLES
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Two-wire bus pins.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Supply supervision.
    input  wire logic       power_fail,
    // Timekeeping core side.
    output logic            time_freeze,
    output logic            divider_reset,
    output logic [2:0]      word_address,
    // Register port toward the timekeeping core.
    input  wire logic       core_wr_en,
    input  wire logic [2:0] core_wr_addr,
    input  wire logic [7:0] core_wr_data,
    output logic            bus_wr_en,
    output logic [2:0]      bus_wr_addr,
    output logic [7:0]      bus_wr_data
);

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic [2:0] pf_sync_q;
    logic       scl_q;
    logic       sda_q;
    logic       pf_q;
    logic       scl_prev_q;
    logic       sda_prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            pf_sync_q  <= 3'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            pf_sync_q  <= {pf_sync_q[1:0], power_fail};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            pf_q  <= 1'b0;
        end else begin
            if (scl_sync_q[1] == scl_sync_q[2]) begin
                scl_q <= scl_sync_q[2];
            end
            if (sda_sync_q[1] == sda_sync_q[2]) begin
                sda_q <= sda_sync_q[2];
            end
            if (pf_sync_q[1] == pf_sync_q[2]) begin
                pf_q <= pf_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_q && !scl_prev_q;
    assign scl_fall  = !scl_q && scl_prev_q;
    assign start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q;
    assign stop_det  = scl_q && scl_prev_q && !sda_prev_q && sda_q;

    // Bus lockout during power fail and recovery.
    logic [31:0] rec_cnt_q;
    logic        locked;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rec_cnt_q <= 32'h0;
        end else if (pf_q) begin
            rec_cnt_q <= REC_CYCLES;
        end else if (rec_cnt_q != 32'h0) begin
            rec_cnt_q <= rec_cnt_q - 32'h1;
        end
    end

    assign locked = pf_q || (rec_cnt_q != 32'h0);

    function automatic logic [2:0] ptr_next(input logic [2:0] p);
        return (p == `RTCSL_PTR_CALIB) ? `RTCSL_PTR_RESET : p + 3'h1;
    endfunction : ptr_next

    // Protocol engine.
    rtcsl_pkg::rtcsl_state_e state_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic        read_q;
    logic        have_ptr_q;
    logic        ack_drive_q;
    logic        last_rx_q;
    logic        time_wr_q;
    logic [2:0]  ptr_q;
    logic [7:0]  rd_byte;
    logic [7:0]  tx_q;

    // Byte received once the eighth rising edge has been seen.
    logic rx_done;
    assign rx_done = scl_rise && (bit_cnt_q == 3'h7);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= rtcsl_pkg::RTCSL_IDLE;
            bit_cnt_q   <= 3'h0;
            shift_q     <= 8'h00;
            read_q      <= 1'b0;
            have_ptr_q  <= 1'b0;
            ack_drive_q <= 1'b0;
            last_rx_q   <= 1'b0;
        end else if (locked) begin
            state_q     <= rtcsl_pkg::RTCSL_IDLE;
            bit_cnt_q   <= 3'h0;
            ack_drive_q <= 1'b0;
            have_ptr_q  <= 1'b0;
        end else if (start_det) begin
            state_q     <= rtcsl_pkg::RTCSL_ADDR;
            bit_cnt_q   <= 3'h0;
            ack_drive_q <= 1'b0;
            have_ptr_q  <= 1'b0;
        end else if (stop_det) begin
            state_q     <= rtcsl_pkg::RTCSL_IDLE;
            ack_drive_q <= 1'b0;
        end else begin
            case (state_q)
                rtcsl_pkg::RTCSL_ADDR, rtcsl_pkg::RTCSL_RX: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_q};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                    end
                    if (rx_done) begin
                        last_rx_q <= 1'b1;
                    end else if (scl_fall && last_rx_q) begin
                        last_rx_q <= 1'b0;
                        if (state_q == rtcsl_pkg::RTCSL_ADDR) begin
                            if (shift_q[7:1] == `RTCSL_DEV_ADDR) begin
                                read_q      <= shift_q[0];
                                ack_drive_q <= 1'b1;
                                state_q     <= rtcsl_pkg::RTCSL_ACK;
                            end else begin
                                state_q <= rtcsl_pkg::RTCSL_IGN;
                            end
                        end else begin
                            ack_drive_q <= 1'b1;
                            state_q     <= rtcsl_pkg::RTCSL_ACK;
                        end
                    end
                end
                rtcsl_pkg::RTCSL_ACK: begin
                    if (scl_fall) begin
                        ack_drive_q <= 1'b0;
                        bit_cnt_q   <= 3'h0;
                        if (read_q) begin
                            state_q <= rtcsl_pkg::RTCSL_TX;
                        end else begin
                            state_q    <= rtcsl_pkg::RTCSL_RX;
                            have_ptr_q <= 1'b1;
                        end
                    end
                end
                rtcsl_pkg::RTCSL_TX: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            state_q <= rtcsl_pkg::RTCSL_TXACK;
                        end
                    end
                end
                rtcsl_pkg::RTCSL_TXACK: begin
                    if (scl_rise) begin
                        // Master nack ends the read; SDA stays released.
                        state_q <= sda_q ? rtcsl_pkg::RTCSL_IGN : rtcsl_pkg::RTCSL_TXACK;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 3'h0;
                        state_q   <= rtcsl_pkg::RTCSL_TX;
                    end
                end
                rtcsl_pkg::RTCSL_IGN: begin
                    bit_cnt_q <= 3'h0;
                end
                default: begin
                    state_q <= rtcsl_pkg::RTCSL_IDLE;
                end
            endcase
        end
    end

    // The address acknowledge only arms the flag, so its byte never reaches the pointer.
    logic       first_byte_q;
    logic       ack_clk_done;
    logic       store_ev;
    logic       ptr_load_ev;

    assign ack_clk_done = (state_q == rtcsl_pkg::RTCSL_ACK) && scl_fall && !read_q && !locked
                          && !start_det && !stop_det;
    assign ptr_load_ev  = ack_clk_done && have_ptr_q && first_byte_q;
    assign store_ev     = ack_clk_done && have_ptr_q && !first_byte_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            first_byte_q <= 1'b0;
        end else if (locked || start_det) begin
            first_byte_q <= 1'b0;
        end else if (state_q == rtcsl_pkg::RTCSL_ADDR && scl_fall && last_rx_q) begin
            first_byte_q <= 1'b1;
        end else if (ack_clk_done && have_ptr_q) begin
            first_byte_q <= 1'b0;
        end
    end

    // Read pointer advance happens on the acknowledge clock's rising edge.
    logic tx_ack_ev;
    assign tx_ack_ev = (state_q == rtcsl_pkg::RTCSL_TXACK) && scl_rise && !sda_q && !locked
                       && !start_det && !stop_det;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= `RTCSL_PTR_RESET;
        end else if (pf_q) begin
            ptr_q <= `RTCSL_PTR_RESET;
        end else if (ptr_load_ev) begin
            ptr_q <= shift_q[2:0];
        end else if (store_ev || tx_ack_ev) begin
            ptr_q <= ptr_next(ptr_q);
        end
    end

    // Bus writes leave through a registered port toward the core.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_wr_en   <= 1'b0;
            bus_wr_addr <= `RTCSL_PTR_RESET;
            bus_wr_data <= `RTCSL_DATA_RESET;
        end else begin
            bus_wr_en   <= store_ev;
            bus_wr_addr <= ptr_q;
            bus_wr_data <= shift_q;
        end
    end

    // The mirror is loaded by bus writes and core updates; a bus write wins a tie,
    // and core updates are dropped while time_freeze is high.
    logic       mem_wr_en;
    logic [2:0] mem_wr_addr;
    logic [7:0] mem_wr_data;

    assign mem_wr_en   = store_ev || (core_wr_en && !time_freeze);
    assign mem_wr_addr = store_ev ? ptr_q : core_wr_addr;
    assign mem_wr_data = store_ev ? shift_q : core_wr_data;

    rtcsl_regmem u_regmem (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .rd_addr (ptr_q),
        .rd_data (rd_byte)
    );

    // Transmit byte is captured as the byte slot opens.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_q <= 8'hff;
        end else if (state_q != rtcsl_pkg::RTCSL_TX) begin
            tx_q <= rd_byte;
        end else if (scl_fall) begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    // Freeze holds while a time register is addressed within an access.
    logic active;
    assign active = (state_q != rtcsl_pkg::RTCSL_IDLE) && (state_q != rtcsl_pkg::RTCSL_ADDR);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            time_freeze <= 1'b0;
        end else begin
            time_freeze <= active && !locked && (ptr_q <= `RTCSL_PTR_LAST_TIME);
        end
    end

    // Divider reset fires at the stop that completes a time write.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            time_wr_q <= 1'b0;
        end else if (locked || start_det && !time_wr_q) begin
            time_wr_q <= 1'b0;
        end else if (store_ev && ptr_q <= `RTCSL_PTR_LAST_TIME) begin
            time_wr_q <= 1'b1;
        end else if (stop_det) begin
            time_wr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divider_reset <= 1'b0;
        end else begin
            divider_reset <= stop_det && time_wr_q && !locked;
        end
    end

    // Open-drain data pin: only ever pulled low.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe <= 1'b0;
        end else if (locked || start_det || stop_det) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= ack_drive_q || (state_q == rtcsl_pkg::RTCSL_TX && !tx_q[7]);
        end
    end

    assign sda_o        = 1'b0;
    assign word_address = ptr_q;

endmodule : rtcsl_slave

// ===== dv/rtcsl_slave_monitor.sv
`timescale 1ns/1ps
module rtcsl_slave_monitor #(
    parameter int unsigned REC_CYCLES = 20
) (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rst_b,
    // Bus pins and supply.
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       power_fail,
    // Core side.
    input wire logic       time_freeze,
    input wire logic       divider_reset,
    input wire logic [2:0] word_address,
    input wire logic       bus_wr_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Cycles since the supply came back; saturates so that reset means recovered.
    logic [31:0] rec_cnt_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rec_cnt_q <= 32'(REC_CYCLES);
        end else if (power_fail) begin
            rec_cnt_q <= 32'h0;
        end else if (rec_cnt_q < 32'(REC_CYCLES)) begin
            rec_cnt_q <= rec_cnt_q + 32'h1;
        end
    end

    AST_OD_LOW: assert property (sda_o == 1'b0)
        else $error("data pin output level not low");
    AST_PF_PTR: assert property (power_fail [*7] |-> word_address == 3'h0 && !sda_oe)
        else $error("power fail did not clear pointer or release data");
    AST_PF_NOWR: assert property (power_fail [*7] |-> !bus_wr_en)
        else $error("register write during power fail");
    AST_REC_QUIET: assert property (rec_cnt_q > 32'h0 && rec_cnt_q < 32'(REC_CYCLES)
        |-> !sda_oe && !bus_wr_en)
        else $error("bus answered during recovery");
    AST_WR_ONE: assert property (bus_wr_en |=> !bus_wr_en)
        else $error("register write pulse longer than one cycle");
    AST_DIV_STOP: assert property (divider_reset |-> scl_i ##1 !divider_reset)
        else $error("divider reset pulse malformed");
    AST_FREEZE_CAL: assert property ((word_address == 3'h7) [*3] |-> !time_freeze)
        else $error("time freeze held at calibration pointer");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) && !power_fail |-> !scl_i)
        else $error("data changed while bus clock high");

    CV_DIV: cover property (divider_reset);
    CV_WRAP: cover property (bus_wr_en && word_address == 3'h0);
    CV_PF: cover property ($fell(power_fail));
endmodule : rtcsl_slave_monitor

bind rtcsl_slave rtcsl_slave_monitor #(.REC_CYCLES(REC_CYCLES)) u_rtcsl_slave_monitor (
    .clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .power_fail(power_fail), .time_freeze(time_freeze), .divider_reset(divider_reset),
    .word_address(word_address), .bus_wr_en(bus_wr_en)
);

// ===== dv/rtcsl_bus_master.sv
`timescale 1ns/1ps
module rtcsl_bus_master (
    // Clock and device data drive.
    input wire logic clk,
    input wire logic sda_oe,
    // Resolved bus lines.
    output logic     scl,
    output logic     sda
);
    logic m_low;
    initial begin
        scl = 1'b1;
        m_low = 1'b0;
    end
    // Pull-up: a released line reads high, never the last driven value.
    assign sda = ~(m_low | sda_oe);

    task automatic hold();
        repeat (12) @(posedge clk);
    endtask : hold

    task automatic start();
        m_low <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        m_low <= 1'b1;
        hold();
        scl <= 1'b0;
        hold();
    endtask : start

    task automatic stop();
        m_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        m_low <= 1'b0;
        hold();
    endtask : stop

    task automatic bit_io(input logic b, output logic r);
        m_low <= ~b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda;
        scl <= 1'b0;
        hold();
    endtask : bit_io

    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ak, a);
    endtask : xfer
endmodule : rtcsl_bus_master

// ===== dv/rtcsl_slave_tb.sv
`timescale 1ns/1ps
module rtcsl_slave_tb;
    // Long enough that an address byte still lands inside the blocked span.
    localparam int unsigned REC = 400;
    logic        clk, rst_b, scl_i, sda_i, sda_o, sda_oe, power_fail;
    logic        time_freeze, divider_reset, core_wr_en, bus_wr_en, a;
    logic [2:0]  word_address, core_wr_addr, bus_wr_addr;
    logic [7:0]  core_wr_data, bus_wr_data, q;
    logic [7:0]  d [4];
    logic [10:0] e;
    logic [10:0] wq [$];
    logic [15:0] rnd_q = 16'h73a5;
    int          errors, n_tests, n_div;

    rtcsl_slave #(.REC_CYCLES(REC)) u_rtcsl_slave (
        .clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe(sda_oe), .power_fail(power_fail), .time_freeze(time_freeze),
        .divider_reset(divider_reset), .word_address(word_address),
        .core_wr_en(core_wr_en), .core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data),
        .bus_wr_en(bus_wr_en), .bus_wr_addr(bus_wr_addr), .bus_wr_data(bus_wr_data)
    );
    rtcsl_bus_master u_rtcsl_bus_master (.clk(clk), .sda_oe(sda_oe), .scl(scl_i), .sda(sda_i));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    function automatic logic [15:0] xs(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        x ^= x << 8;
        return x;
    endfunction : xs

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("errors=%0d tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic xb(input logic [7:0] dv, input logic ak);
        u_rtcsl_bus_master.xfer(dv, ak, q, a);
    endtask : xb

    task automatic sel(input logic [7:0] ab, input logic ex);
        u_rtcsl_bus_master.start();
        xb(ab, 1'b1);
        check({7'h0, a}, {7'h0, ex});
    endtask : sel

    task automatic wr_ptr(input logic [2:0] p);
        sel(8'hd0, 1'b0);
        xb({5'h0, p}, 1'b1);
        check({7'h0, a}, 8'h00);
    endtask : wr_ptr

    // Every stored byte is matched against the oldest noted write.
    always @(posedge clk) begin
        if (divider_reset === 1'b1) n_div++;
        if (bus_wr_en === 1'b1) begin
            e = (wq.size() != 0) ? wq.pop_front() : 11'bx;
            check({5'h0, bus_wr_addr}, {5'h0, e[10:8]});
            check(bus_wr_data, e[7:0]);
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        rst_b = 1'b0;
        power_fail = 1'b0;
        core_wr_en = 1'b0;
        core_wr_addr = 3'h0;
        core_wr_data = 8'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        check({5'h0, word_address}, 8'h00);
        check({6'h0, sda_oe, time_freeze}, 8'h00);
        wr_ptr(3'h5);
        check({7'h0, time_freeze}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            rnd_q = xs(rnd_q);
            d[i] = rnd_q[7:0];
            wq.push_back({3'(i + 5), d[i]});
            xb(d[i], 1'b1);
            check({7'h0, a}, 8'h00);
        end
        u_rtcsl_bus_master.stop();
        check({5'h0, word_address}, 8'h01);
        check({7'h0, time_freeze}, 8'h00);
        check(8'(n_div), 8'h01);
        wr_ptr(3'h5);
        sel(8'hd1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            xb(8'hff, i == 3);
            check(q, d[i]);
        end
        u_rtcsl_bus_master.stop();
        check({5'h0, word_address}, 8'h00);
        check({7'h0, sda_oe}, 8'h00);
        rnd_q = xs(rnd_q);
        core_wr_addr <= 3'h0;
        core_wr_data <= rnd_q[7:0];
        core_wr_en <= 1'b1;
        @(posedge clk);
        core_wr_en <= 1'b0;
        sel(8'hd1, 1'b0);
        xb(8'hff, 1'b1);
        check(q, rnd_q[7:0]);
        u_rtcsl_bus_master.stop();
        sel(8'ha0, 1'b1);
        xb(8'h00, 1'b1);
        check({7'h0, a}, 8'h01);
        u_rtcsl_bus_master.stop();
        wr_ptr(3'h3);
        for (int i = 0; i < 4; i++) u_rtcsl_bus_master.bit_io(rnd_q[i], a);
        u_rtcsl_bus_master.stop();
        check({5'h0, word_address}, 8'h03);
        sel(8'hd0, 1'b0);
        u_rtcsl_bus_master.stop();
        check({5'h0, word_address}, 8'h03);
        wr_ptr(3'h2);
        power_fail <= 1'b1;
        repeat (8) @(posedge clk);
        check({5'h0, word_address}, 8'h00);
        xb(8'h5a, 1'b1);
        check({7'h0, a}, 8'h01);
        power_fail <= 1'b0;
        u_rtcsl_bus_master.stop();
        sel(8'hd0, 1'b1);
        u_rtcsl_bus_master.stop();
        repeat (REC) @(posedge clk);
        wr_ptr(3'h4);
        check({5'h0, word_address}, 8'h04);
        u_rtcsl_bus_master.stop();
        repeat (20) @(posedge clk);
        check(8'(wq.size()), 8'h00);
        check(8'(n_div), 8'h01);
        give_verdict();
    end
endmodule : rtcsl_slave_tb
